// ---- core/evf_pkg.sv ----
// constants and helpers for the event and shutdown-cause flag block
// assumes one system clock; all users import the whole package
package evf_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int           REG_W          = 8;
    localparam logic [7:0]   ADDR_INT_FLAGS = 8'h04;
    localparam logic [7:0]   ADDR_CAUSE     = 8'h05;
    localparam logic [7:0]   RST_INT_FLAGS  = 8'h00;
    localparam logic [7:0]   RST_CAUSE      = 8'h00;
    localparam logic [7:0]   RD_UNMAPPED    = 8'h00;
    localparam logic [7:0]   INT_USED_MASK  = 8'h7f;

    // ****************************************************************
    // interrupt flag bit positions
    // ****************************************************************
    localparam int BIT_RESERVED     = 7;
    localparam int BIT_LIN1_FAULT   = 6;
    localparam int BIT_LIN0_FAULT   = 5;
    localparam int BIT_BB_TIMEOUT   = 4;
    localparam int BIT_PIN2_RISE    = 3;
    localparam int BIT_PIN2_FALL    = 2;
    localparam int BIT_PIN1_RISE    = 1;
    localparam int BIT_PIN1_FALL    = 0;

    // ****************************************************************
    // shutdown cause bit positions
    // ****************************************************************
    localparam int BIT_WD_RESET     = 7;
    localparam int BIT_WD_POWEROFF  = 6;
    localparam int BIT_SW_COLD      = 5;
    localparam int BIT_SW_OFF       = 4;
    localparam int BIT_MANUAL_RST   = 3;
    localparam int BIT_SUPPLY_UV    = 2;
    localparam int BIT_SUPPLY_OV    = 1;
    localparam int BIT_THERMAL      = 0;

    // ****************************************************************
    // encodings and timing
    // ****************************************************************
    localparam logic [1:0] SW_CTRL_COLD_RST = 2'h1;
    localparam logic [1:0] SW_CTRL_POWEROFF = 2'h2;
    localparam logic       WD_ACT_RESET     = 1'h1;
    localparam int         PIN_SETTLE_CYC   = 3;
    localparam logic [2:0] SETTLE_RST       = 3'h0;

    typedef logic [REG_W-1:0] evf_byte_t;

    // next value of a clear-on-read flag byte: a set wins over the clear
    function automatic evf_byte_t evf_next(input evf_byte_t cur,
                                           input logic      clr,
                                           input evf_byte_t set);
        evf_next = (clr ? RST_INT_FLAGS : cur) | set;
    endfunction

endpackage

// ---- core/evf_pin_edge.sv ----
// two-flop synchroniser and edge detector for one general-purpose pin
// assumes the pin is asynchronous to i_clk
`timescale 1ns/1ps
`default_nettype none
module evf_pin_edge
    import evf_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // pin and its configuration
    input  wire logic i_pin,
    input  wire logic i_is_input,
    // edge pulses
    output logic      o_rise,
    output logic      o_fall
);

    logic                      meta_ff;
    logic                      sync_ff;
    logic                      prev_ff;
    logic [PIN_SETTLE_CYC-1:0] settle_ff;
    logic                      armed;

    // ****************************************************************
    // synchroniser and history
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_ff   <= 1'b0;
            sync_ff   <= 1'b0;
            prev_ff   <= 1'b0;
            settle_ff <= SETTLE_RST;
        end else begin
            meta_ff   <= i_pin;
            sync_ff   <= meta_ff;
            prev_ff   <= sync_ff;
            settle_ff <= {settle_ff[PIN_SETTLE_CYC-2:0], 1'b1};
        end
    end

    // no edges until the history holds a real pin level
    assign armed  = settle_ff[PIN_SETTLE_CYC-1] & i_is_input;
    assign o_rise = armed & sync_ff & ~prev_ff;
    assign o_fall = armed & ~sync_ff & prev_ff;

endmodule
`default_nettype wire

// ---- core/evf_flag_reg.sv ----
// one byte of sticky flags, cleared as a whole when the byte is read
// assumes set pulses and the clear come from logic on i_clk
`timescale 1ns/1ps
`default_nettype none
module evf_flag_reg
    import evf_pkg::*;
(
    // clock and reset
    input  wire logic      i_clk,
    input  wire logic      i_rst,
    // events and read clear
    input  wire evf_byte_t i_set,
    input  wire logic      i_clr,
    // flags and flags that turned on now
    output evf_byte_t      o_flags,
    output evf_byte_t      o_new
);

    evf_byte_t flags_ff;
    evf_byte_t nxt_flags;

    assign nxt_flags = evf_next(flags_ff, i_clr, i_set);
    assign o_flags   = flags_ff;
    // a bit read away in this cycle and set again counts as new
    assign o_new     = i_set & (~flags_ff | {REG_W{i_clr}});

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flags_ff <= RST_INT_FLAGS;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

endmodule
`default_nettype wire

// ---- core/evf_event_flags.sv ----
// event flag and shutdown-cause flag registers with interrupt output
// assumes the host read port and all event pulses run on i_clk;
// only the two pins are asynchronous and are synchronised here
`timescale 1ns/1ps
`default_nettype none

// Contract
// - interrupt flag bit 7 is reserved; never set, reads zero
// - linear regulator 1 fault sets bit 6, held until read
// - linear regulator 0 fault sets bit 5, held until read
// - buck-boost timeout sets bit 4, held until read
// - pin 2 as input: rising edge sets bit 3, falling bit 2
// - pin 1 as input: rising edge sets bit 1, falling bit 0
// - reading 0x04 returns the flags, then clears them all
// - watchdog expiry with reset action sets cause bit 7
// - watchdog expiry with power-off action sets cause bit 6
// - software control write of 01 sets cause bit 5
// - software control write of 10 sets cause bit 4
// - manual reset sets cause bit 3, held until read
// - supply undervoltage lockout sets cause bit 2
// - supply overvoltage lockout sets cause bit 1
// - thermal overload sets cause bit 0
// - reading 0x05 returns the causes, then clears them all
// - interrupt goes low on unmasked new flag, high when all clear
module evf_event_flags
    import evf_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // register read port
    input  wire logic       i_rd_en,
    input  wire logic [7:0] i_rd_addr,
    output logic [7:0]      o_rd_data,
    output logic            o_rd_valid,
    // software control field write
    input  wire logic       i_sw_ctrl_wr,
    input  wire logic [1:0] i_sw_ctrl_val,
    // interrupt masks, bit n masks flag bit n, 1 = masked
    input  wire logic [6:0] i_int_mask,
    // regulator events
    input  wire logic       i_lin1_fault,
    input  wire logic       i_lin0_fault,
    input  wire logic       i_buckboost_timeout,
    // general-purpose pins
    input  wire logic       i_pin1,
    input  wire logic       i_pin2,
    input  wire logic       i_pin1_is_input,
    input  wire logic       i_pin2_is_input,
    // shutdown cause events
    input  wire logic       i_watchdog_expire,
    input  wire logic       i_watchdog_action_select,
    input  wire logic       i_manual_reset,
    input  wire logic       i_supply_uv,
    input  wire logic       i_supply_ov,
    input  wire logic       i_thermal_overload,
    // interrupt line
    output logic            o_interrupt_out_n
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic       pin1_rise;
    logic       pin1_fall;
    logic       pin2_rise;
    logic       pin2_fall;
    logic       rd_int;
    logic       rd_cause;
    logic       sw_cold;
    logic       sw_off;
    evf_byte_t  int_set;
    evf_byte_t  cause_set;
    evf_byte_t  int_flags;
    evf_byte_t  int_new;
    evf_byte_t  cause_flags;
    evf_byte_t  rd_mux;
    evf_byte_t  int_next;
    evf_byte_t  unmasked;
    logic       irq_raise;
    logic       irq_hold;
    logic       nxt_irq;
    logic [7:0] rd_data_ff;
    logic       rd_valid_ff;
    logic       irq_ff;
    logic       out_n_ff;

    // ****************************************************************
    // pin edge detection
    // ****************************************************************
    evf_pin_edge u_pin1 (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_pin      (i_pin1),
        .i_is_input (i_pin1_is_input),
        .o_rise     (pin1_rise),
        .o_fall     (pin1_fall)
    );

    evf_pin_edge u_pin2 (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_pin      (i_pin2),
        .i_is_input (i_pin2_is_input),
        .o_rise     (pin2_rise),
        .o_fall     (pin2_fall)
    );

    // ****************************************************************
    // address decode and event collection
    // ****************************************************************
    assign rd_int   = i_rd_en & (i_rd_addr == ADDR_INT_FLAGS);
    assign rd_cause = i_rd_en & (i_rd_addr == ADDR_CAUSE);
    assign sw_cold  = i_sw_ctrl_wr & (i_sw_ctrl_val == SW_CTRL_COLD_RST);
    assign sw_off   = i_sw_ctrl_wr & (i_sw_ctrl_val == SW_CTRL_POWEROFF);

    always_comb begin
        int_set                  = RST_INT_FLAGS;
        int_set[BIT_RESERVED]    = 1'b0;
        int_set[BIT_LIN1_FAULT]  = i_lin1_fault;
        int_set[BIT_LIN0_FAULT]  = i_lin0_fault;
        int_set[BIT_BB_TIMEOUT]  = i_buckboost_timeout;
        int_set[BIT_PIN2_RISE]   = pin2_rise;
        int_set[BIT_PIN2_FALL]   = pin2_fall;
        int_set[BIT_PIN1_RISE]   = pin1_rise;
        int_set[BIT_PIN1_FALL]   = pin1_fall;
    end

    always_comb begin
        cause_set = RST_CAUSE;
        cause_set[BIT_WD_RESET] = i_watchdog_expire &
            (i_watchdog_action_select == WD_ACT_RESET);
        cause_set[BIT_WD_POWEROFF] = i_watchdog_expire &
            (i_watchdog_action_select != WD_ACT_RESET);
        cause_set[BIT_SW_COLD]    = sw_cold;
        cause_set[BIT_SW_OFF]     = sw_off;
        cause_set[BIT_MANUAL_RST] = i_manual_reset;
        cause_set[BIT_SUPPLY_UV]  = i_supply_uv;
        cause_set[BIT_SUPPLY_OV]  = i_supply_ov;
        cause_set[BIT_THERMAL]    = i_thermal_overload;
    end

    // ****************************************************************
    // flag registers, set wins over the read clear
    // ****************************************************************
    evf_flag_reg u_int_flags (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_set   (int_set),
        .i_clr   (rd_int),
        .o_flags (int_flags),
        .o_new   (int_new)
    );

    evf_flag_reg u_cause_flags (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_set   (cause_set),
        .i_clr   (rd_cause),
        .o_flags (cause_flags),
        .o_new   ()
    );

    // ****************************************************************
    // read data, reserved bit forced low
    // ****************************************************************
    assign rd_mux = rd_int   ? (int_flags & INT_USED_MASK) :
                    rd_cause ? cause_flags : RD_UNMAPPED;

    // ****************************************************************
    // interrupt line
    // ****************************************************************
    assign int_next  = evf_next(int_flags, rd_int, int_set);
    assign unmasked  = {1'b0, ~i_int_mask};
    assign irq_raise = |(int_new & unmasked);
    assign irq_hold  = irq_ff & (|int_next);
    assign nxt_irq   = irq_raise | irq_hold;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_data_ff  <= RD_UNMAPPED;
            rd_valid_ff <= 1'b0;
            irq_ff      <= 1'b0;
            out_n_ff    <= 1'b1;
        end else begin
            rd_data_ff  <= rd_mux;
            rd_valid_ff <= i_rd_en;
            irq_ff      <= nxt_irq;
            out_n_ff    <= ~nxt_irq;
        end
    end

    assign o_rd_data         = rd_data_ff;
    assign o_rd_valid        = rd_valid_ff;
    assign o_interrupt_out_n = out_n_ff;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    reserved_low_a: assert property (!int_flags[BIT_RESERVED])
        else $error("reserved flag bit set");
    lin1_flag_a: assert property (i_lin1_fault |=>
        int_flags[BIT_LIN1_FAULT]) else $error("lin1 flag missing");
    lin0_flag_a: assert property (i_lin0_fault |=>
        int_flags[BIT_LIN0_FAULT]) else $error("lin0 flag missing");
    bb_flag_hold_a: assert property (int_flags[BIT_BB_TIMEOUT]
        && !rd_int |=> int_flags[BIT_BB_TIMEOUT])
        else $error("timeout flag dropped without read");
    pin2_edge_a: assert property (pin2_rise |=>
        int_flags[BIT_PIN2_RISE]) else $error("pin2 rise flag missing");
    pin2_fall_a: assert property (pin2_fall |=>
        int_flags[BIT_PIN2_FALL]) else $error("pin2 fall flag missing");
    pin1_edge_a: assert property (pin1_fall |=>
        int_flags[BIT_PIN1_FALL]) else $error("pin1 fall flag missing");
    pin1_rise_a: assert property (pin1_rise |=>
        int_flags[BIT_PIN1_RISE]) else $error("pin1 rise flag missing");
    bb_flag_set_a: assert property (i_buckboost_timeout |=>
        int_flags[BIT_BB_TIMEOUT]) else $error("timeout flag missing");
    pin1_refused_a: assert property (!i_pin1_is_input && !rd_int
        |=> $stable(int_flags[BIT_PIN1_RISE:BIT_PIN1_FALL]))
        else $error("pin1 edge flagged while not an input");
    pin2_refused_a: assert property (!i_pin2_is_input && !rd_int
        |=> $stable(int_flags[BIT_PIN2_RISE:BIT_PIN2_FALL]))
        else $error("pin2 edge flagged while not an input");
    int_read_a: assert property (rd_int |=> o_rd_valid &&
        o_rd_data == ($past(int_flags) & INT_USED_MASK))
        else $error("interrupt flag read data wrong");
    int_clear_a: assert property (rd_int && int_set == '0
        |=> int_flags == '0) else $error("interrupt flags not cleared");
    reserved_read_a: assert property (rd_int |=>
        !o_rd_data[BIT_RESERVED]) else $error("reserved bit read as one");
    unmapped_read_a: assert property (i_rd_en && !rd_int &&
        !rd_cause |=> o_rd_data == RD_UNMAPPED)
        else $error("unmapped read returned data");
    valid_pulse_a: assert property (!i_rd_en |=> !o_rd_valid)
        else $error("read valid without a read");
    int_keep_a: assert property (!rd_int |=>
        (int_flags & $past(int_flags)) == $past(int_flags))
        else $error("interrupt flag dropped without read");

    // ****************************************************************
    // cause flag checks
    // ****************************************************************
    wd_reset_a: assert property (i_watchdog_expire &&
        i_watchdog_action_select |=> cause_flags[BIT_WD_RESET])
        else $error("watchdog reset cause missing");
    wd_off_a: assert property (i_watchdog_expire &&
        !i_watchdog_action_select && !rd_cause
        |=> cause_flags[BIT_WD_POWEROFF] && !cause_flags[BIT_WD_RESET]
            == !$past(cause_flags[BIT_WD_RESET]))
        else $error("watchdog poweroff cause wrong");
    sw_cold_a: assert property (i_sw_ctrl_wr &&
        i_sw_ctrl_val == SW_CTRL_COLD_RST |=> cause_flags[BIT_SW_COLD])
        else $error("software cold reset cause missing");
    sw_off_a: assert property (i_sw_ctrl_wr &&
        i_sw_ctrl_val == SW_CTRL_POWEROFF |=> cause_flags[BIT_SW_OFF])
        else $error("software off cause missing");
    sw_refused_a: assert property (i_sw_ctrl_wr && !rd_cause &&
        i_sw_ctrl_val != SW_CTRL_COLD_RST &&
        i_sw_ctrl_val != SW_CTRL_POWEROFF
        |=> $stable(cause_flags[BIT_SW_COLD:BIT_SW_OFF]))
        else $error("ignored control value set a cause");
    manual_rst_a: assert property (i_manual_reset ##1
        (!rd_cause)[*2] |=> cause_flags[BIT_MANUAL_RST])
        else $error("manual reset cause not held");
    supply_uv_a: assert property (i_supply_uv |=>
        cause_flags[BIT_SUPPLY_UV]) else $error("undervoltage missing");
    supply_ov_a: assert property (i_supply_ov |=>
        cause_flags[BIT_SUPPLY_OV]) else $error("overvoltage missing");
    thermal_a: assert property (i_thermal_overload |=>
        cause_flags[BIT_THERMAL]) else $error("thermal cause missing");
    cause_read_a: assert property (rd_cause && cause_set == '0
        |=> o_rd_data == $past(cause_flags) && cause_flags == '0)
        else $error("cause read or clear wrong");
    cause_keep_a: assert property (!rd_cause |=>
        (cause_flags & $past(cause_flags)) == $past(cause_flags))
        else $error("cause flag dropped without read");

    // ****************************************************************
    // interrupt line checks, plus set winning over the read clear
    // ****************************************************************
    irq_low_a: assert property (|(int_new & unmasked)
        |=> !o_interrupt_out_n) else $error("interrupt not asserted");
    irq_high_a: assert property (int_flags == '0
        |-> o_interrupt_out_n) else $error("interrupt stuck low");
    irq_quiet_a: assert property (o_interrupt_out_n &&
        !(|(int_new & unmasked)) |=> o_interrupt_out_n)
        else $error("interrupt fell without a new flag");
    set_wins_a: assert property (rd_int && int_set != '0
        |=> (int_flags & $past(int_set)) == $past(int_set))
        else $error("event lost in clearing read");

    // ****************************************************************
    // cover properties
    // ****************************************************************
    irq_cycle_c: cover property (!o_interrupt_out_n ##1 rd_int
        ##1 o_interrupt_out_n);
    cause_read_c: cover property (cause_flags != '0 ##1 rd_cause);
    race_c: cover property (rd_int && int_set != '0);
    pin_edges_c: cover property (pin1_rise ##[1:20] pin1_fall);
    masked_c: cover property (int_new != '0 && (int_new & unmasked) == '0);

endmodule
`default_nettype wire

// ---- testbench/evf_host_model.sv ----
// host-side model that reads the flag registers one byte per request
// assumes the design takes a read on the rising edge with the enable high
`timescale 1ns/1ps
`default_nettype none
module evf_host_model
    import evf_pkg::*;
(
    // clock
    input  wire logic       i_clk,
    // read request
    output logic            o_rd_en,
    output logic [7:0]      o_rd_addr,
    // read answer
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_rd_valid
);
    logic [7:0] last_addr;

    initial begin
        o_rd_en   = 1'h0;
        o_rd_addr = 8'h00;
        last_addr = 8'h00;
    end

    // ****************************************************************
    // read tasks
    // ****************************************************************
    // one read request; hands back what the previous cycle's read gave
    task automatic issue(input  logic [7:0] addr,
                         output logic [7:0] prev,
                         output logic       prev_vld);
        @(posedge i_clk);
        o_rd_en   <= 1'h1;
        o_rd_addr <= addr;
        last_addr = addr;
        #1;
        prev     = i_rd_data;
        prev_vld = i_rd_valid;
    endtask

    // release the request; an idle address shows the inverse of the last
    task automatic finish(output logic [7:0] data, output logic vld);
        @(posedge i_clk);
        o_rd_en   <= 1'h0;
        o_rd_addr <= ~last_addr;
        #1;
        // reads only: the reserved bit is never written
        data = i_rd_data;
        vld  = i_rd_valid;
    endtask
endmodule
`default_nettype wire

// ---- testbench/event_and_reset_cause_flags_tb.sv ----
// self-checking bench for the event and shutdown-cause flag block
// assumes evf_pkg, the design files and evf_host_model compile first
`timescale 1ns/1ps
`default_nettype none
module event_and_reset_cause_flags_tb;
    typedef struct packed {
        logic [11:0] ev;
        logic [7:0]  addr;
        logic [7:0]  exp;
        logic        irq_n;
    } evf_row_t;

    logic        i_clk = 1'h0;
    logic        i_rst, i_rd_en, i_sw_ctrl_wr, o_rd_valid, o_interrupt_out_n;
    logic [7:0]  i_rd_addr, o_rd_data, d1, d2;
    logic [1:0]  i_sw_ctrl_val;
    logic [6:0]  i_int_mask;
    logic        i_lin1_fault, i_lin0_fault, i_buckboost_timeout;
    logic        i_pin1, i_pin2, i_pin1_is_input, i_pin2_is_input;
    logic        i_watchdog_expire, i_watchdog_action_select;
    logic        i_manual_reset, i_supply_uv, i_supply_ov, i_thermal_overload;
    logic        v1, v2;
    int          errors = 0;
    int          checks_done = 0;
    logic [1:0]  pin_lv [6] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h3, 2'h0};
    logic [7:0]  pin_ex [6] = '{8'h02, 8'h01, 8'h08, 8'h04, 8'h00, 8'h00};
    // ev bits: lin1 lin0 timeout wd_expire wd_act sw_wr sw_val[2]
    //          manual uv ov thermal
    evf_row_t    rows [13] = '{
        {12'h001, 8'h04, 8'h40, 1'h0},
        {12'h002, 8'h04, 8'h20, 1'h0},
        {12'h004, 8'h04, 8'h10, 1'h0},
        {12'h018, 8'h05, 8'h80, 1'h1},
        {12'h008, 8'h05, 8'h40, 1'h1},
        {12'h060, 8'h05, 8'h20, 1'h1},
        {12'h0a0, 8'h05, 8'h10, 1'h1},
        {12'h020, 8'h05, 8'h00, 1'h1},
        {12'h0e0, 8'h05, 8'h00, 1'h1},
        {12'h100, 8'h05, 8'h08, 1'h1},
        {12'h200, 8'h05, 8'h04, 1'h1},
        {12'h400, 8'h05, 8'h02, 1'h1},
        {12'h800, 8'h05, 8'h01, 1'h1}
    };

    always #2 i_clk = ~i_clk;

    evf_event_flags DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_rd_en(i_rd_en),
        .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid), .i_sw_ctrl_wr(i_sw_ctrl_wr),
        .i_sw_ctrl_val(i_sw_ctrl_val), .i_int_mask(i_int_mask),
        .i_lin1_fault(i_lin1_fault), .i_lin0_fault(i_lin0_fault),
        .i_buckboost_timeout(i_buckboost_timeout), .i_pin1(i_pin1),
        .i_pin2(i_pin2), .i_pin1_is_input(i_pin1_is_input),
        .i_pin2_is_input(i_pin2_is_input),
        .i_watchdog_expire(i_watchdog_expire),
        .i_watchdog_action_select(i_watchdog_action_select),
        .i_manual_reset(i_manual_reset), .i_supply_uv(i_supply_uv),
        .i_supply_ov(i_supply_ov), .i_thermal_overload(i_thermal_overload),
        .o_interrupt_out_n(o_interrupt_out_n));

    evf_host_model host (
        .i_clk(i_clk), .o_rd_en(i_rd_en), .o_rd_addr(i_rd_addr),
        .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid));

    // ****************************************************************
    // helper tasks
    // ****************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t ns: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host.issue(a, d1, v1);
        host.finish(d2, v2);
        check({7'h00, v2}, 8'h01);
        check(d2, exp);
    endtask

    task automatic drive_ev(input logic [11:0] ev);
        i_lin1_fault             <= ev[0];
        i_lin0_fault             <= ev[1];
        i_buckboost_timeout      <= ev[2];
        i_watchdog_expire        <= ev[3];
        i_watchdog_action_select <= ev[4];
        i_sw_ctrl_wr             <= ev[5];
        i_sw_ctrl_val            <= ev[7:6];
        i_manual_reset           <= ev[8];
        i_supply_uv              <= ev[9];
        i_supply_ov              <= ev[10];
        i_thermal_overload       <= ev[11];
    endtask

    task automatic pulse_ev(input logic [11:0] ev);
        @(posedge i_clk);
        drive_ev(ev);
        @(posedge i_clk);
        drive_ev(12'h000);
        repeat (2) @(posedge i_clk);
        #1;
    endtask

    task automatic reset_dut();
        @(posedge i_clk);
        i_rst <= 1'h1;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'h0;
        @(posedge i_clk);
        #1;
        check({7'h00, o_interrupt_out_n}, 8'h01);
        check({7'h00, o_rd_valid}, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h05, 8'h00);
        repeat (4) @(posedge i_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (3000) @(posedge i_clk);
        errors++;
        tally_and_finish();
    end

    initial begin
        i_rst           <= 1'h1;
        i_int_mask      <= 7'h00;
        i_pin1          <= 1'h0;
        i_pin2          <= 1'h0;
        i_pin1_is_input <= 1'h1;
        i_pin2_is_input <= 1'h1;
        drive_ev(12'h000);
        reset_dut();
        $display("done: reset values");
        foreach (rows[i]) begin
            pulse_ev(rows[i].ev);
            check({7'h00, o_interrupt_out_n}, 8'(rows[i].irq_n));
            rd(rows[i].addr, rows[i].exp);
            rd(rows[i].addr, 8'h00);
            check({7'h00, o_interrupt_out_n}, 8'h01);
        end
        $display("done: event table");
        for (int k = 0; k < 6; k++) begin
            @(posedge i_clk);
            {i_pin2, i_pin1} <= pin_lv[k];
            i_pin1_is_input  <= (k < 4);
            i_pin2_is_input  <= (k < 4);
            repeat (6) @(posedge i_clk);
            rd(8'h04, pin_ex[k]);
        end
        $display("done: pin edges");
        pulse_ev(12'h002);
        rd(8'h07, 8'h00);
        rd(8'h04, 8'h20);
        $display("done: unmapped read");
        @(posedge i_clk) i_int_mask <= 7'h40;
        pulse_ev(12'h001);
        check({7'h00, o_interrupt_out_n}, 8'h01);
        @(posedge i_clk) i_int_mask <= 7'h00;
        repeat (3) @(posedge i_clk);
        #1;
        check({7'h00, o_interrupt_out_n}, 8'h01);
        rd(8'h04, 8'h40);
        $display("done: masking");
        pulse_ev(12'h004);
        fork
            host.issue(8'h04, d1, v1);
            begin @(posedge i_clk); i_buckboost_timeout <= 1'h1; end
        join
        fork
            host.finish(d2, v2);
            begin @(posedge i_clk); i_buckboost_timeout <= 1'h0; end
        join
        check(d2, 8'h10);
        rd(8'h04, 8'h10);
        $display("done: event during read");
        pulse_ev(12'h802);
        host.issue(8'h04, d1, v1);
        host.issue(8'h05, d1, v1);
        host.finish(d2, v2);
        check(d1, 8'h20);
        check(d2, 8'h01);
        check({6'h00, v1, v2}, 8'h03);
        $display("done: back to back reads");
        pulse_ev(12'h001);
        reset_dut();
        $display("done: reset in mid-run");
        tally_and_finish();
    end
endmodule
`default_nettype wire
